//--- src/pcb_device.sv
`timescale 1ns/1ps
module pcb_device
   import pcb_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   pcb_if.device bus,
   input wire logic [15:0] strap_in,
   input wire logic por_in,
   output logic pll_reset_out,
   output logic pll_locked_out,
   output logic reg_write_out,
   output logic [7:0] reg_write_offset_out,
   output logic [15:0] reg_write_data_out
);
   import pcb_pkg::*;

   localparam int LOCK_W = $clog2(PLL_LOCK_CYCLES + 1);
   localparam logic [LOCK_W-1:0] LOCK_DONE = LOCK_W'(PLL_LOCK_CYCLES);

   typedef struct packed {
      logic [127:0][15:0] regs;
      logic [1:0][15:0] strap_sync;
      logic [1:0] por_sync;
      logic [LOCK_W-1:0] lock_cnt;
      logic locked;
      logic ack;
      logic hit;
      logic [15:0] rdata;
      logic wr_stb;
      logic [7:0] wr_off;
      logic [15:0] wr_data;
      // Reset seen on the previous edge
      logic was_reset;
   } dev_state_t;

   // Peripheral that each offset is decoded to; all registers sit in regs here
   typedef enum logic [2:0] {
      OWNER_NONE = 3'b000,
      OWNER_SERIAL = 3'b001,
      OWNER_IRQ = 3'b010,
      OWNER_TIMER = 3'b011,
      OWNER_GPIO = 3'b100,
      OWNER_SELECT = 3'b101,
      OWNER_DMA = 3'b110,
      OWNER_CONTROL = 3'b111
   } owner_t;

   dev_state_t st;
   dev_state_t next_st;
   logic [7:0] off;
   logic [6:0] idx;
   logic [7:0] word_off;
   owner_t owner;
   logic in_window;
   logic mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   assign off = bus.addr[7:0];
   // Bit 0 dropped: an odd offset reaches the word at the even offset below it
   assign idx = off[7:1];
   // Upper byte against relocation base, space must agree
   assign in_window = (bus.addr[15:8] == st.regs[WINDOW_RELOCATION[7:1]][RELOC_BASE_LSB +: 8])
      && (bus.mem_space == st.regs[WINDOW_RELOCATION[7:1]][RELOC_MEM_BIT]);
   assign word_off = {idx, 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   // Owner decode
   // One table for the whole window, while every register sits in regs in this
   // module; a new peripheral also needs its offsets added to offset_mapped
   always_comb
   begin
      owner = OWNER_NONE;
      case (word_off)
         SERIAL1_CONTROL, SERIAL1_STATUS, SERIAL1_TRANSMIT, SERIAL1_RECEIVE,
         SERIAL1_BAUD_DIVISOR, SERIAL0_CONTROL, SERIAL0_STATUS, SERIAL0_TRANSMIT,
         SERIAL0_RECEIVE, SERIAL0_BAUD_DIVISOR:
            owner = OWNER_SERIAL;
         IRQ_VECTOR, IRQ_END_OF_SERVICE, IRQ_POLL, IRQ_POLL_STATUS, IRQ_MASK,
         IRQ_PRIORITY_MASK, IRQ_IN_SERVICE, IRQ_REQUEST, IRQ_STATUS, TIMER_IRQ_CONTROL,
         DMA0_EXT5_IRQ_CONTROL, DMA1_EXT6_IRQ_CONTROL, EXT0_IRQ_CONTROL, EXT1_IRQ_CONTROL,
         EXT2_IRQ_CONTROL, EXT3_IRQ_CONTROL, EXT4_IRQ_CONTROL, SERIAL1_IRQ_CONTROL,
         SERIAL0_IRQ_CONTROL:
            owner = OWNER_IRQ;
         TIMER0_COUNT, TIMER0_COMPARE_A, TIMER0_COMPARE_B, TIMER0_MODE,
         TIMER1_COUNT, TIMER1_COMPARE_A, TIMER1_COMPARE_B, TIMER1_MODE,
         TIMER2_COUNT, TIMER2_COMPARE_A, TIMER2_MODE:
            owner = OWNER_TIMER;
         GPIO0_MODE, GPIO0_DIRECTION, GPIO0_DATA, GPIO1_MODE, GPIO1_DIRECTION, GPIO1_DATA:
            owner = OWNER_GPIO;
         UPPER_MEMORY_SELECT, LOWER_MEMORY_SELECT, PERIPHERAL_SELECT,
         MIDRANGE_MEMORY_SELECT, SELECT_AUXILIARY:
            owner = OWNER_SELECT;
         CLOCK_PRESCALER, RCU_ENABLE, WATCHDOG_CONTROL, SYSTEM_CONFIG, AUX_CONFIG,
         RELEASE_LEVEL, RESET_CONFIG, WINDOW_RELOCATION:
            owner = OWNER_CONTROL;
         default:
         begin
            // Six word registers per channel, the gap between channels reserved
            if (((word_off >= DMA0_BASE) && (word_off <= DMA0_LAST))
               || ((word_off >= DMA1_BASE) && (word_off <= DMA1_LAST)))
            begin
               owner = OWNER_DMA;
            end
            else
            begin
               // No partition register: its old offset stays reserved
               owner = OWNER_NONE;
            end
         end
      endcase
   end

   assign mapped = (owner != OWNER_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      next_st = st;
      next_st.strap_sync = {st.strap_sync[0], strap_in};
      next_st.por_sync = {st.por_sync[0], por_in};
      next_st.ack = 1'b0;
      next_st.wr_stb = 1'b0;
      // PLL lock follows power-on alone, not the processor reset
      if (st.por_sync[1])
      begin
         next_st.lock_cnt = '0;
         next_st.locked = 1'b0;
      end
      else if (st.lock_cnt != LOCK_DONE)
      begin
         next_st.lock_cnt = st.lock_cnt + 1'b1;
      end
      else
      begin
         next_st.locked = 1'b1;
      end
      next_st.was_reset = !nrst_in;
      // Straps arrive two edges late through the synchroniser, so a short
      // reset would miss them: taken once more on the first edge after it
      if (nrst_in && st.was_reset)
      begin
         next_st.regs[RESET_CONFIG[7:1]] = st.strap_sync[1];
      end
      if (!nrst_in)
      begin
         next_st.regs = '0;
         next_st.regs[WINDOW_RELOCATION[7:1]] = RELOC_RESET;
         next_st.regs[RELEASE_LEVEL[7:1]] = RELEASE_RESET;
         // Straps followed through reset
         next_st.regs[RESET_CONFIG[7:1]] = st.strap_sync[1];
         next_st.hit = 1'b0;
         next_st.rdata = '0;
         next_st.wr_off = '0;
         next_st.wr_data = '0;
      end
      else if (bus.req && !st.ack && st.locked)
      begin
         next_st.ack = 1'b1;
         next_st.hit = in_window;
         next_st.rdata = '0;
         // Width of the overlaid space and the access size do not matter here
         if (in_window && mapped)
         begin
            if (bus.write)
            begin
               next_st.regs[idx] = bus.wdata;
               next_st.wr_stb = 1'b1;
               next_st.wr_off = {idx, 1'b0};
               next_st.wr_data = bus.wdata;
            end
            else
            begin
               next_st.rdata = st.regs[idx];
            end
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign bus.ack = st.ack;
   assign bus.hit = st.hit;
   assign bus.rdata = st.rdata;
   assign pll_reset_out = st.por_sync[1];
   assign pll_locked_out = st.locked;
   assign reg_write_out = st.wr_stb;
   assign reg_write_offset_out = st.wr_off;
   assign reg_write_data_out = st.wr_data;
endmodule // pcb_device

//--- src/pcb_pkg.sv
package pcb_pkg;
   // Register offsets inside the peripheral_register_window
   localparam logic [7:0] SERIAL1_CONTROL = 8'h10;
   localparam logic [7:0] SERIAL1_STATUS = 8'h12;
   localparam logic [7:0] SERIAL1_TRANSMIT = 8'h14;
   localparam logic [7:0] SERIAL1_RECEIVE = 8'h16;
   localparam logic [7:0] SERIAL1_BAUD_DIVISOR = 8'h18;
   localparam logic [7:0] IRQ_VECTOR = 8'h20;
   localparam logic [7:0] IRQ_END_OF_SERVICE = 8'h22;
   localparam logic [7:0] IRQ_POLL = 8'h24;
   localparam logic [7:0] IRQ_POLL_STATUS = 8'h26;
   localparam logic [7:0] IRQ_MASK = 8'h28;
   localparam logic [7:0] IRQ_PRIORITY_MASK = 8'h2A;
   localparam logic [7:0] IRQ_IN_SERVICE = 8'h2C;
   localparam logic [7:0] IRQ_REQUEST = 8'h2E;
   localparam logic [7:0] IRQ_STATUS = 8'h30;
   localparam logic [7:0] TIMER_IRQ_CONTROL = 8'h32;
   localparam logic [7:0] DMA0_EXT5_IRQ_CONTROL = 8'h34;
   localparam logic [7:0] DMA1_EXT6_IRQ_CONTROL = 8'h36;
   localparam logic [7:0] EXT0_IRQ_CONTROL = 8'h38;
   localparam logic [7:0] EXT1_IRQ_CONTROL = 8'h3A;
   localparam logic [7:0] EXT2_IRQ_CONTROL = 8'h3C;
   localparam logic [7:0] EXT3_IRQ_CONTROL = 8'h3E;
   localparam logic [7:0] EXT4_IRQ_CONTROL = 8'h40;
   localparam logic [7:0] SERIAL1_IRQ_CONTROL = 8'h42;
   localparam logic [7:0] SERIAL0_IRQ_CONTROL = 8'h44;
   localparam logic [7:0] TIMER0_COUNT = 8'h50;
   localparam logic [7:0] TIMER0_COMPARE_A = 8'h52;
   localparam logic [7:0] TIMER0_COMPARE_B = 8'h54;
   localparam logic [7:0] TIMER0_MODE = 8'h56;
   localparam logic [7:0] TIMER1_COUNT = 8'h58;
   localparam logic [7:0] TIMER1_COMPARE_A = 8'h5A;
   localparam logic [7:0] TIMER1_COMPARE_B = 8'h5C;
   localparam logic [7:0] TIMER1_MODE = 8'h5E;
   localparam logic [7:0] TIMER2_COUNT = 8'h60;
   localparam logic [7:0] TIMER2_COMPARE_A = 8'h62;
   localparam logic [7:0] TIMER2_MODE = 8'h66;
   localparam logic [7:0] GPIO0_MODE = 8'h70;
   localparam logic [7:0] GPIO0_DIRECTION = 8'h72;
   localparam logic [7:0] GPIO0_DATA = 8'h74;
   localparam logic [7:0] GPIO1_MODE = 8'h76;
   localparam logic [7:0] GPIO1_DIRECTION = 8'h78;
   localparam logic [7:0] GPIO1_DATA = 8'h7A;
   localparam logic [7:0] SERIAL0_CONTROL = 8'h80;
   localparam logic [7:0] SERIAL0_STATUS = 8'h82;
   localparam logic [7:0] SERIAL0_TRANSMIT = 8'h84;
   localparam logic [7:0] SERIAL0_RECEIVE = 8'h86;
   localparam logic [7:0] SERIAL0_BAUD_DIVISOR = 8'h88;
   localparam logic [7:0] UPPER_MEMORY_SELECT = 8'hA0;
   localparam logic [7:0] LOWER_MEMORY_SELECT = 8'hA2;
   localparam logic [7:0] PERIPHERAL_SELECT = 8'hA4;
   localparam logic [7:0] MIDRANGE_MEMORY_SELECT = 8'hA6;
   localparam logic [7:0] SELECT_AUXILIARY = 8'hA8;
   localparam logic [7:0] DMA0_BASE = 8'hC0;
   localparam logic [7:0] DMA0_LAST = 8'hCA;
   localparam logic [7:0] DMA1_BASE = 8'hD0;
   localparam logic [7:0] DMA1_LAST = 8'hDA;
   localparam logic [7:0] CLOCK_PRESCALER = 8'hE2;
   localparam logic [7:0] RCU_ENABLE = 8'hE4;
   localparam logic [7:0] WATCHDOG_CONTROL = 8'hE6;
   localparam logic [7:0] SYSTEM_CONFIG = 8'hF0;
   localparam logic [7:0] AUX_CONFIG = 8'hF2;
   localparam logic [7:0] RELEASE_LEVEL = 8'hF4;
   localparam logic [7:0] RESET_CONFIG = 8'hF6;
   localparam logic [7:0] WINDOW_RELOCATION = 8'hFE;

   // Relocation layout: base upper address byte, and space select bit
   localparam int RELOC_BASE_LSB = 0;
   localparam int RELOC_MEM_BIT = 12;
   localparam logic [15:0] RELOC_RESET = 16'h00FF;
   // Arbitrary value, no meaning beyond this design
   localparam logic [15:0] RELEASE_RESET = 16'h0001;

   // PLL multiplies by one: internal clock equals crystal frequency
   localparam int PLL_MULTIPLY = 1;
   localparam int CLK_PERIOD_NS = 20;
   localparam int PLL_LOCK_NS = 2000;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   function automatic logic offset_mapped(input logic [7:0] off);
      logic hit;
      hit = 1'b0;
      case (off)
         SERIAL1_CONTROL, SERIAL1_STATUS, SERIAL1_TRANSMIT, SERIAL1_RECEIVE,
         SERIAL1_BAUD_DIVISOR, IRQ_VECTOR, IRQ_END_OF_SERVICE, IRQ_POLL,
         IRQ_POLL_STATUS, IRQ_MASK, IRQ_PRIORITY_MASK, IRQ_IN_SERVICE, IRQ_REQUEST,
         IRQ_STATUS, TIMER_IRQ_CONTROL, DMA0_EXT5_IRQ_CONTROL, DMA1_EXT6_IRQ_CONTROL,
         EXT0_IRQ_CONTROL, EXT1_IRQ_CONTROL, EXT2_IRQ_CONTROL, EXT3_IRQ_CONTROL,
         EXT4_IRQ_CONTROL, SERIAL1_IRQ_CONTROL, SERIAL0_IRQ_CONTROL,
         TIMER0_COUNT, TIMER0_COMPARE_A, TIMER0_COMPARE_B, TIMER0_MODE,
         TIMER1_COUNT, TIMER1_COMPARE_A, TIMER1_COMPARE_B, TIMER1_MODE,
         TIMER2_COUNT, TIMER2_COMPARE_A, TIMER2_MODE,
         GPIO0_MODE, GPIO0_DIRECTION, GPIO0_DATA, GPIO1_MODE, GPIO1_DIRECTION, GPIO1_DATA,
         SERIAL0_CONTROL, SERIAL0_STATUS, SERIAL0_TRANSMIT, SERIAL0_RECEIVE,
         SERIAL0_BAUD_DIVISOR, UPPER_MEMORY_SELECT, LOWER_MEMORY_SELECT,
         PERIPHERAL_SELECT, MIDRANGE_MEMORY_SELECT, SELECT_AUXILIARY,
         CLOCK_PRESCALER, RCU_ENABLE, WATCHDOG_CONTROL, SYSTEM_CONFIG, AUX_CONFIG,
         RELEASE_LEVEL, RESET_CONFIG, WINDOW_RELOCATION:
            hit = 1'b1;
         default:
            hit = ((off >= DMA0_BASE) && (off <= DMA0_LAST))
               || ((off >= DMA1_BASE) && (off <= DMA1_LAST));
      endcase
      return hit;
   endfunction

   typedef enum logic [1:0] {
      HOST_IDLE = 2'b00,
      HOST_WAIT = 2'b01
   } host_state_t;
endpackage

//--- src/pcb_if.sv
`timescale 1ns/1ps
interface pcb_if;
   logic req;
   logic write;
   logic byte_size;
   logic mem_space;
   logic narrow_bus;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic hit;
   logic [15:0] rdata;

   modport device (input req, write, byte_size, mem_space, narrow_bus, addr, wdata,
                   output ack, hit, rdata);
   modport core (output req, write, byte_size, mem_space, narrow_bus, addr, wdata,
                 input ack, hit, rdata);
endinterface

//--- src/pcb_core.sv
`timescale 1ns/1ps
module pcb_core
   import pcb_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   pcb_if.core bus,
   input wire logic narrow_bus_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic cmd_mem_in,
   input wire logic [15:0] cmd_addr_in,
   input wire logic [15:0] cmd_data_in,
   output logic cmd_ready_out,
   output logic done_out,
   output logic done_hit_out,
   output logic done_err_out,
   output logic [15:0] done_data_out
);
   import pcb_pkg::*;

   typedef struct packed {
      host_state_t state;
      logic req;
      logic write;
      logic mem;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] base;
      logic done;
      logic hit;
      logic err;
      logic [15:0] rdata;
   } core_state_t;

   core_state_t st;
   core_state_t next_st;
   logic targets_window;

   // Shadow of the relocation register tracks where the window sits
   assign targets_window = (cmd_addr_in[15:8] == st.base[RELOC_BASE_LSB +: 8])
      && (cmd_mem_in == st.base[RELOC_MEM_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;
      if (!nrst_in)
      begin
         next_st = '0;
         next_st.state = HOST_IDLE;
         next_st.base = RELOC_RESET;
      end
      else
      begin
         case (st.state)
            HOST_IDLE:
            begin
               if (cmd_valid_in)
               begin
                  if (targets_window && (cmd_addr_in[0] || !offset_mapped(cmd_addr_in[7:0])))
                  begin
                     next_st.done = 1'b1;
                     next_st.err = 1'b1;
                     next_st.hit = 1'b0;
                     next_st.rdata = '0;
                  end
                  else
                  begin
                     next_st.state = HOST_WAIT;
                     next_st.req = 1'b1;
                     next_st.write = cmd_write_in;
                     next_st.mem = cmd_mem_in;
                     next_st.addr = cmd_addr_in;
                     next_st.wdata = cmd_data_in;
                  end
               end
            end
            HOST_WAIT:
            begin
               if (bus.ack)
               begin
                  next_st.state = HOST_IDLE;
                  next_st.req = 1'b0;
                  next_st.done = 1'b1;
                  next_st.err = 1'b0;
                  next_st.hit = bus.hit;
                  next_st.rdata = st.write ? 16'h0000 : bus.rdata;
                  if (bus.hit && st.write && (st.addr[7:0] == WINDOW_RELOCATION))
                  begin
                     next_st.base = st.wdata;
                  end
               end
            end
            default:
            begin
               next_st.state = HOST_IDLE;
               next_st.req = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   assign bus.req = st.req;
   assign bus.write = st.write;
   // Writes go out byte-sized, reads word-sized
   assign bus.byte_size = st.write;
   assign bus.mem_space = st.mem;
   assign bus.narrow_bus = narrow_bus_in;
   assign bus.addr = st.addr;
   assign bus.wdata = st.wdata;
   assign cmd_ready_out = (st.state == HOST_IDLE);
   assign done_out = st.done;
   assign done_hit_out = st.hit;
   assign done_err_out = st.err;
   assign done_data_out = st.rdata;
endmodule // pcb_core

//--- bench/pcb_assertions.sv
`timescale 1ns/1ps
module pcb_assertions
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic req,
   input wire logic write,
   input wire logic byte_size,
   input wire logic mem_space,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic hit,
   input wire logic [15:0] rdata
);
   logic [7:0] base;
   logic mem_sel;
   logic in_win;

   // Shadow of the window base, so decode is judged on its own
   assign in_win = (addr[15:8] == base) && (mem_space == mem_sel);

   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         base <= 8'hFF;
         mem_sel <= 1'b0;
      end
      else if (ack && hit && write && (addr[7:1] == 7'h7F))
      begin
         base <= wdata[7:0];
         mem_sel <= wdata[12];
      end
   end

   ////////////////////////////////////////
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   a_ack_bounded: assert property ($rose(req) |-> ##[1:120] ack)
      else $error("no answer to request");
   a_ack_caused: assert property (ack |-> $past(req))
      else $error("answer without request");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("answer longer than one cycle");
   a_hit_window: assert property (ack |-> hit == in_win)
      else $error("window match wrong");
   a_miss_zero: assert property (ack && !hit |-> rdata == 16'h0000)
      else $error("data on miss");
   a_rdata_held: assert property (!ack |-> $stable(rdata))
      else $error("read data changed between answers");
   a_byte_write: assert property (req |-> byte_size == write)
      else $error("access size wrong");
   a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
      else $error("request changed before answer");
   a_req_release: assert property (ack |=> !req)
      else $error("request held after answer");
   a_no_odd: assert property (req && in_win |-> !addr[0])
      else $error("misaligned access in window");

   c_write: cover property (ack && hit && write);
   c_read: cover property (ack && hit && !write);
   c_miss: cover property (ack && !hit);
endmodule // pcb_assertions

//--- bench/peripheral_register_block_bench.sv
`timescale 1ns/1ps
module peripheral_register_block_bench;
   import pcb_pkg::*;
   localparam logic [15:0] STRAP = 16'h3C5A;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic por_in = 1'b1;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_mem = 1'b0, narrow = 1'b0;
   logic [15:0] cmd_addr = 16'h0000, cmd_data = 16'h0000;
   logic ready, done, done_hit, done_err, pll_rst, pll_lock, wr_pulse, rdy;
   logic [15:0] done_data, wr_data, got, lat;
   logic [7:0] wr_off;
   logic [7:0] offs [18] = '{8'h10, 8'h18, 8'h20, 8'h44, 8'h50, 8'h66, 8'h70, 8'h7A, 8'h80,
      8'h88, 8'hA0, 8'hA8, 8'hC0, 8'hCA, 8'hD0, 8'hDA, 8'hE2, 8'hE6};
   logic [7:0] rsv [7] = '{8'h00, 8'h1A, 8'h68, 8'h8A, 8'hCC, 8'hDE, 8'hF8};
   int fails = 0, n_checks = 0, cyc = 0, n_wr = 0, n0;

   pcb_if bus();
   pcb_device i_pcb_device(.clk_in(clk_in), .nrst_in(nrst_in), .bus(bus), .strap_in(STRAP),
      .por_in(por_in), .pll_reset_out(pll_rst), .pll_locked_out(pll_lock),
      .reg_write_out(wr_pulse), .reg_write_offset_out(wr_off), .reg_write_data_out(wr_data));
   pcb_core i_pcb_core(.clk_in(clk_in), .nrst_in(nrst_in), .bus(bus), .narrow_bus_in(narrow),
      .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_mem_in(cmd_mem),
      .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_ready_out(ready), .done_out(done),
      .done_hit_out(done_hit), .done_err_out(done_err), .done_data_out(done_data));
   pcb_assertions i_pcb_assertions(.clk_in(clk_in), .nrst_in(nrst_in), .req(bus.req),
      .write(bus.write), .byte_size(bus.byte_size), .mem_space(bus.mem_space),
      .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack), .hit(bus.hit), .rdata(bus.rdata));

   always #10 clk_in = ~clk_in;

   // Stored-write strobe count, and the hang limit
   always @(posedge clk_in)
   begin
      cyc++;
      if (wr_pulse === 1'b1)
         n_wr++;
      if (cyc == 4000)
      begin
         fails++;
         close_out();
      end
   end

   ////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic wr, mem, input logic [15:0] a, d);
      @(negedge clk_in);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_mem = mem;
      cmd_addr = a;
      cmd_data = d;
      @(negedge clk_in);
      cmd_valid = 1'b0;
      rdy = ready;
      lat = 16'h0001;
      while (done !== 1'b1 && lat < 16'h0032)
      begin
         @(negedge clk_in);
         lat++;
      end
      got = done_data;
   endtask

   task automatic xfer(input logic wr, mem, input logic [15:0] a, d, exp, input logic hit);
      cmd(wr, mem, a, d);
      chk(lat, 16'h0003);
      chk({15'h0000, rdy}, 16'h0000);
      chk({15'h0000, ready}, 16'h0001);
      chk({15'h0000, done_hit}, {15'h0000, hit});
      chk({15'h0000, done_err}, 16'h0000);
      chk(got, exp);
   endtask

   // Odd or reserved offsets inside the window never reach the bus
   task automatic refused(input logic wr, input logic [15:0] a);
      cmd(wr, 1'b0, a, 16'hFFFF);
      chk({15'h0000, done_err}, 16'h0001);
      chk(lat, 16'h0001);
      chk({15'h0000, rdy}, 16'h0001);
      chk({15'h0000, done_hit}, 16'h0000);
      chk(got, 16'h0000);
   endtask

   task automatic t_pll();
      repeat (2) @(negedge clk_in);
      chk({15'h0000, pll_rst}, 16'h0001);
      chk({15'h0000, pll_lock}, 16'h0000);
      por_in = 1'b0;
      lat = 16'h0000;
      while (pll_lock !== 1'b1 && lat < 16'h012C)
      begin
         @(negedge clk_in);
         lat++;
      end
      chk({15'h0000, pll_rst}, 16'h0000);
      chk({15'h0000, lat >= 16'h0064 && lat < 16'h012C}, 16'h0001);
      $display("t_pll done");
   endtask

   task automatic t_reset();
      xfer(1'b0, 1'b0, 16'hFFF6, 16'h0000, STRAP, 1'b1);
      xfer(1'b0, 1'b0, 16'hFFF4, 16'h0000, RELEASE_RESET, 1'b1);
      xfer(1'b0, 1'b0, 16'hFFFE, 16'h0000, RELOC_RESET, 1'b1);
      xfer(1'b0, 1'b0, 16'hFF10, 16'h0000, 16'h0000, 1'b1);
      $display("t_reset done");
   endtask

   // Byte writes carry a full word; high byte differs from low on purpose
   task automatic t_rw(input logic nb);
      narrow = nb;
      foreach (offs[i])
      begin
         xfer(1'b1, 1'b0, {8'hFF, offs[i]},
            {~offs[i], offs[i]} ^ {16{nb}}, 16'h0000, 1'b1);
         chk(wr_data, {~offs[i], offs[i]} ^ {16{nb}});
         chk({8'h00, wr_off}, {8'h00, offs[i]});
      end
      foreach (offs[i])
         xfer(1'b0, 1'b0, {8'hFF, offs[i]}, 16'h0000,
            {~offs[i], offs[i]} ^ {16{nb}}, 1'b1);
      $display("t_rw done");
   endtask

   task automatic t_reserved();
      n0 = n_wr;
      foreach (rsv[i])
      begin
         refused(1'b1, {8'hFF, rsv[i]});
         refused(1'b0, {8'hFF, rsv[i]});
      end
      chk(16'(n_wr - n0), 16'h0000);
      $display("t_reserved done");
   endtask

   task automatic t_odd();
      n0 = n_wr;
      refused(1'b1, 16'hFF11);
      refused(1'b0, 16'hFF13);
      xfer(1'b0, 1'b0, 16'hFF10, 16'h0000, 16'h10EF, 1'b1);
      chk(16'(n_wr - n0), 16'h0000);
      $display("t_odd done");
   endtask

   task automatic t_miss();
      n0 = n_wr;
      xfer(1'b1, 1'b0, 16'h1210, 16'hAAAA, 16'h0000, 1'b0);
      xfer(1'b0, 1'b1, 16'hFF10, 16'h0000, 16'h0000, 1'b0);
      chk(16'(n_wr - n0), 16'h0000);
      $display("t_miss done");
   endtask

   // Move the window into memory space and back again
   task automatic t_reloc();
      xfer(1'b1, 1'b0, 16'hFFFE, 16'h1012, 16'h0000, 1'b1);
      xfer(1'b0, 1'b1, 16'h1210, 16'h0000, 16'h10EF, 1'b1);
      xfer(1'b0, 1'b0, 16'hFF10, 16'h0000, 16'h0000, 1'b0);
      xfer(1'b1, 1'b1, 16'h12FE, 16'h00FF, 16'h0000, 1'b1);
      xfer(1'b0, 1'b0, 16'hFFFE, 16'h0000, 16'h00FF, 1'b1);
      $display("t_reloc done");
   endtask

   task automatic close_out();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(negedge clk_in);
      nrst_in = 1'b1;
      t_pll();
      t_reset();
      t_rw(1'b0);
      t_rw(1'b1);
      t_reserved();
      t_odd();
      t_miss();
      t_reloc();
      close_out();
   end
endmodule // peripheral_register_block_bench
